// File: design/pt_pkg.sv
// package: register map, field layout and reset values of the period timer
package pt_pkg;
    // offsets are register indexes; byte address is four times the index
    localparam logic [7:0] IDX_FLAGS   = 8'h0C;
    localparam logic [7:0] IDX_COUNT   = 8'h11;
    localparam logic [7:0] IDX_CONTROL = 8'h12;
    localparam logic [7:0] IDX_ENABLES = 8'h8C;
    localparam logic [7:0] IDX_PERIOD  = 8'h92;

    localparam logic [7:0] RST_FLAGS   = 8'h00;
    localparam logic [7:0] RST_COUNT   = 8'h00;
    localparam logic [6:0] RST_CONTROL = 7'h00;
    localparam logic [7:0] RST_ENABLES = 8'h00;
    localparam logic [7:0] RST_PERIOD  = 8'hFF;

    localparam int CTL_PRE_LSB   = 0;
    localparam int CTL_RUN_BIT   = 2;
    localparam int CTL_POST_LSB  = 3;
    localparam int FLAG_MATCH_BIT = 1;

    localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
    localparam logic [3:0] PRE_LAST_4     = 4'h3;
    localparam logic [3:0] PRE_LAST_16    = 4'hF;

    typedef enum logic [1:0] {
        PT_PRE_1,
        PT_PRE_4,
        PT_PRE_16
    } pt_pre_t;
endpackage

// File: design/pt_tick_if.sv
// interface: timing ticks and clears between the timer core and scaler
`timescale 1ns/1ps
interface pt_tick_if;
    logic       scaler_clr;
    logic       run;
    logic [1:0] pre_sel;
    logic       tick;
    modport core   (output scaler_clr, output run, output pre_sel,
                    input tick);
    modport scaler (input scaler_clr, input run, input pre_sel,
                    output tick);
endinterface

// File: design/pt_prescaler.sv
// module: instruction clock divider and selectable 1/4/16 prescaler
`timescale 1ns/1ps
module pt_prescaler
    import pt_pkg::*;
(
    input  wire logic mclk,
    input  wire logic rst,
    pt_tick_if.scaler tk
);
    logic [1:0] instr_ff;
    logic [3:0] pre_ff;
    logic       instr_tick;
    logic [3:0] pre_last;
    logic       pre_done;

    assign instr_tick = tk.run && (instr_ff == INSTR_DIV_LAST);
    assign pre_last   = (tk.pre_sel == PT_PRE_1) ? 4'h0 :
                        (tk.pre_sel == PT_PRE_4) ? PRE_LAST_4 :
                        PRE_LAST_16;
    assign pre_done   = (pre_ff >= pre_last);
    assign tk.tick    = instr_tick && pre_done;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            instr_ff <= 2'h0;
            pre_ff   <= 4'h0;
        end else if (tk.scaler_clr) begin
            instr_ff <= 2'h0;
            pre_ff   <= 4'h0;
        end else if (tk.run) begin
            instr_ff <= instr_ff + 2'h1;
            if (instr_tick) begin
                pre_ff <= pre_done ? 4'h0 : pre_ff + 4'h1;
            end
        end
    end
endmodule // pt_prescaler

// File: design/pt_timer.sv
// top: 8-bit period timer with prescaler, postscaler and wishbone slave
// How it works
// - instruction clock is mclk/4, prescaled by 1, 4 or 16 via field
// - count up from zero; after equal to period, next tick returns zero
// - period register read/write, resets to all ones
// - count register read/write, cleared on reset
// - matches pass 4-bit postscaler; completion sets flag bit 1
// - postscale ratio is control bits 6..3 plus one
// - timer advances only while control bit 2 is set
// - count or control write, and reset, clear pre and postscalers
// - control write leaves count unchanged
// - raw match pulse offered to serial port as shift clock
// - count and match offered to pwm unit as time base
// - control bit 7 reads zero; other control bits reset to zero
`timescale 1ns/1ps
module pt_timer
    import pt_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [9:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             period_match,
    output logic      [7:0]  pwm_timebase,
    output logic             period_irq
);
    import pt_pkg::*;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] count_ff;
    logic [7:0] period_ff;
    logic [6:0] control_ff;
    logic       flag_ff;
    logic [7:0] enables_ff;
    logic [3:0] post_ff;
    logic       ack_ff;
    logic [31:0] rdata_ff;
    logic       match_ff;

    pt_tick_if tk ();

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic [7:0] idx;
    logic       req;
    logic       wr;
    logic       wr_lane0;
    logic       hit_flags;
    logic       hit_count;
    logic       hit_control;
    logic       hit_enables;
    logic       hit_period;
    logic       wr_count;
    logic       wr_control;
    logic       wr_flags;
    logic [7:0] wbyte;
    logic [7:0] rbyte;

    assign idx         = wb_adr_i[9:2];
    assign req         = wb_cyc_i && wb_stb_i && !ack_ff;
    // writes land at the edge where the master samples ack
    assign wr          = wb_cyc_i && wb_stb_i && wb_we_i && ack_ff;
    assign wr_lane0    = wr && wb_sel_i[0];
    assign wbyte       = wb_dat_i[7:0];
    assign hit_flags   = (idx == IDX_FLAGS);
    assign hit_count   = (idx == IDX_COUNT);
    assign hit_control = (idx == IDX_CONTROL);
    assign hit_enables = (idx == IDX_ENABLES);
    assign hit_period  = (idx == IDX_PERIOD);
    assign wr_count    = wr_lane0 && hit_count;
    assign wr_control  = wr_lane0 && hit_control;
    assign wr_flags    = wr_lane0 && hit_flags;

    // unmapped indexes read zero and are still acknowledged
    assign rbyte = hit_flags   ? {6'h00, flag_ff, 1'b0} :
                   hit_count   ? count_ff :
                   hit_control ? {1'b0, control_ff} :
                   hit_enables ? enables_ff :
                   hit_period  ? period_ff : 8'h00;

    // ------------------------------------------------------------
    // prescaler hookup
    // ------------------------------------------------------------
    assign tk.scaler_clr = wr_count || wr_control;
    assign tk.run        = control_ff[CTL_RUN_BIT];
    assign tk.pre_sel    = control_ff[CTL_PRE_LSB +: 2];

    pt_prescaler u_pre (
        .mclk (mclk),
        .rst  (rst),
        .tk   (tk.scaler)
    );

    // ------------------------------------------------------------
    // counter, match and postscaler
    // ------------------------------------------------------------
    logic       at_period;
    logic       tick_ok;
    logic       match;
    logic [3:0] post_sel;
    logic       post_done;
    logic       flag_set;
    logic [7:0] nxt_count;
    logic [3:0] nxt_post;

    assign at_period = (count_ff == period_ff);
    // a tick that meets a scaler clear is dropped, so the write wins
    assign tick_ok   = tk.tick && !tk.scaler_clr;
    assign match     = tick_ok && at_period;
    assign post_sel  = control_ff[CTL_POST_LSB +: 4];
    assign post_done = match && (post_ff >= post_sel);
    assign flag_set  = post_done;

    assign nxt_count = wr_count ? wbyte :
                       match ? 8'h00 :
                       tick_ok ? count_ff + 8'h01 : count_ff;
    assign nxt_post  = tk.scaler_clr ? 4'h0 :
                       post_done ? 4'h0 :
                       match ? post_ff + 4'h1 : post_ff;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            count_ff <= RST_COUNT;
            post_ff  <= 4'h0;
            match_ff <= 1'b0;
        end else begin
            count_ff <= nxt_count;
            post_ff  <= nxt_post;
            match_ff <= match;
        end
    end

    // ------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            period_ff  <= RST_PERIOD;
            control_ff <= RST_CONTROL;
            enables_ff <= RST_ENABLES;
        end else begin
            if (wr_lane0 && hit_period) begin
                period_ff <= wbyte;
            end
            if (wr_control) begin
                control_ff <= wbyte[6:0];
            end
            if (wr_lane0 && hit_enables) begin
                enables_ff <= wbyte;
            end
        end
    end

    // set wins over a software clear in the same cycle
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            flag_ff <= RST_FLAGS[FLAG_MATCH_BIT];
        end else if (flag_set) begin
            flag_ff <= 1'b1;
        end else if (wr_flags && !wbyte[FLAG_MATCH_BIT]) begin
            flag_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // bus answer, one wait state
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ack_ff   <= 1'b0;
            rdata_ff <= 32'h0000_0000;
        end else begin
            ack_ff   <= req;
            rdata_ff <= req ? {24'h00_0000, rbyte} : 32'h0000_0000;
        end
    end

    assign wb_ack_o     = ack_ff;
    assign wb_dat_o     = rdata_ff;
    assign period_match = match_ff;
    assign pwm_timebase = count_ff;
    assign period_irq   = flag_ff && enables_ff[FLAG_MATCH_BIT];
endmodule // pt_timer

// File: test/pt_timer_asserts.sv
// checker: bus handshake and timer output properties
`timescale 1ns/1ps
module pt_timer_asserts (
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        period_match,
    input wire logic [7:0]  pwm_timebase,
    input wire logic        period_irq
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    wire req = wb_cyc_i && wb_stb_i;
    wire wr  = req && wb_we_i;
    ack_answer_a: assert property (req && !wb_ack_o |=> wb_ack_o)
        else $error("no ack after request");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_cause_a: assert property (wb_ack_o |-> $past(req))
        else $error("ack without request");
    dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    dat_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("upper read bits set");
    match_gap_a: assert property (period_match |=> !period_match [*3])
        else $error("match pulses too close");
    match_zero_a: assert property (
        period_match |-> pwm_timebase == 8'h00)
        else $error("match without wrap to zero");
    count_step_a: assert property (!$past(wr) && !$past(wr, 2)
        && $changed(pwm_timebase) |-> pwm_timebase == 8'h00
        || pwm_timebase == $past(pwm_timebase) + 8'h01)
        else $error("count jumped");
    irq_sticky_a: assert property (period_irq && !wr |=> period_irq)
        else $error("irq dropped without write");
endmodule // pt_timer_asserts

// File: test/pt_timer_tb.sv
// testbench: register access and timing of the period timer
`timescale 1ns/1ps
module pt_timer_tb;
    import pt_pkg::*;
    logic        mclk, rst, cyc, stb, we, ack, period_match, period_irq;
    logic [9:0]  adr;
    logic [31:0] wdat, rdat;
    logic [7:0]  pwm_timebase, v;
    logic [3:0]  ps, sel, lanes;
    int          miscompares, comparisons, cycles, n, r;

    pt_timer i_dut (.mclk, .rst, .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .period_match, .pwm_timebase,
        .period_irq);

    initial begin
        mclk = 0;
        forever #5 mclk = ~mclk;
    end
    // ------------------------------
    // bus access and checking tasks
    // ------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] i,
                       input logic [7:0] d);
        @(posedge mclk);
        cyc <= 1;
        stb <= 1;
        we <= w;
        sel <= lanes;
        adr <= {i, 2'b00};
        wdat <= {24'h0, d};
        @(posedge mclk);
        while (ack !== 1'b1) @(posedge mclk);
        v = rdat[7:0];
        cyc <= 0;
        stb <= 0;
        we <= 0;
    endtask
    task automatic rc(input logic [7:0] i, input logic [7:0] exp);
        bus(0, i, 8'h00);
        chk(v, exp);
    endtask
    task automatic end_sim;
        $display("miscompares=%0d comparisons=%0d", miscompares, comparisons);
        if (miscompares == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares++;
            end_sim();
        end
    end
    initial begin
        {rst, cyc, stb, we, adr, wdat} = {4'h8, 10'h0, 32'h0};
        {miscompares, comparisons, cycles} = 0;
        {sel, lanes} = 8'hFF;
        repeat (5) @(posedge mclk);
        rst <= 0;
        rc(IDX_FLAGS, RST_FLAGS);
        rc(IDX_COUNT, RST_COUNT);
        rc(IDX_CONTROL, 8'h00);
        rc(IDX_ENABLES, RST_ENABLES);
        rc(IDX_PERIOD, RST_PERIOD);
        rc(8'h01, 8'h00);
        bus(1, IDX_CONTROL, 8'hF8);
        rc(IDX_CONTROL, 8'h78);
        bus(1, IDX_PERIOD, 8'h5A);
        rc(IDX_PERIOD, 8'h5A);
        bus(1, IDX_PERIOD, RST_PERIOD);
        for (int p = 0; p < 4; p++) begin
            r = (p == 0) ? 1 : (p == 1) ? 4 : 16;
            bus(1, IDX_CONTROL, 8'h04 | p[7:0]);
            bus(1, IDX_COUNT, 8'hF0);
            repeat (14 * r - 2) @(posedge mclk);
            rc(IDX_COUNT, 8'hF3);
        end
        rc(IDX_COUNT, 8'hF3);
        bus(1, IDX_CONTROL, 8'h03);
        repeat (100) @(posedge mclk);
        rc(IDX_COUNT, 8'hF3);
        chk(pwm_timebase, 8'hF3);
        bus(1, IDX_PERIOD, 8'h02);
        bus(1, IDX_ENABLES, 8'h02);
        for (int k = 0; k < 3; k++) begin
            ps = (k == 0) ? 4'h0 : (k == 1) ? 4'h1 : 4'hF;
            bus(1, IDX_CONTROL, 8'h00);
            bus(1, IDX_FLAGS, 8'h00);
            bus(1, IDX_COUNT, 8'h00);
            bus(1, IDX_CONTROL, {1'b0, ps, 3'b100});
            n = 0;
            do begin
                @(posedge mclk);
                #1;
                n += period_match;
            end while (period_irq !== 1'b1);
            @(posedge mclk);
            #1;
            n += period_match;
            chk(n[7:0], {4'h0, ps} + 8'h01);
        end
        bus(1, IDX_CONTROL, 8'h00);
        bus(1, IDX_FLAGS, 8'h02);
        rc(IDX_FLAGS, 8'h02);
        bus(1, IDX_ENABLES, 8'h00);
        #1;
        chk({7'h0, period_irq}, 8'h00);
        bus(1, IDX_ENABLES, 8'h02);
        #1;
        chk({7'h0, period_irq}, 8'h01);
        bus(1, IDX_FLAGS, 8'h00);
        #1;
        chk({7'h0, period_irq}, 8'h00);
        bus(1, IDX_PERIOD, 8'h5A);
        bus(1, IDX_COUNT, 8'h33);
        @(posedge mclk);
        rst <= 1;
        repeat (2) @(posedge mclk);
        rst <= 0;
        rc(IDX_COUNT, RST_COUNT);
        rc(IDX_PERIOD, RST_PERIOD);
        rc(IDX_CONTROL, 8'h00);
        rc(IDX_ENABLES, RST_ENABLES);
        lanes = 4'hE;
        bus(1, IDX_PERIOD, 8'h11);
        lanes = 4'hF;
        rc(IDX_PERIOD, RST_PERIOD);
        end_sim();
    end
endmodule // pt_timer_tb

bind pt_timer pt_timer_asserts u_chk (.mclk, .rst, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_dat_o, .wb_ack_o, .period_match, .pwm_timebase,
    .period_irq);
